// ---- bench/host_model.sv ----
module host_model
   import rbc_pkg::*;
(
   input wire logic clk,
   input wire logic pin_low_req,
   input wire logic slow,
   input wire logic [31:0] word_cfg,
   input wire logic flash_init_start,
   output logic reset_pin_n,
   output logic swd_debug_req,
   output logic flash_init_done,
   output logic [31:0] code_read_protection_word
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pin_q = 1'b1;
   logic dbg_q = 1'b0;
   logic [3:0] cnt_q = 4'h0;
   assign reset_pin_n = pin_q;
   assign swd_debug_req = dbg_q;
   assign flash_init_done = (cnt_q == 4'h1);
   // Word is only valid alongside done
   assign code_read_protection_word = flash_init_done ? word_cfg : ~word_cfg;
   always @(posedge clk) begin
      pin_q <= !pin_low_req;
      dbg_q <= !dbg_q;
      if (flash_init_start)
         cnt_q <= slow ? 4'h9 : 4'h2;
      else if (cnt_q != 4'h0)
         cnt_q <= cnt_q - 4'h1;
   end
endmodule

// ---- bench/rbc_checker_properties.sv ----
module rbc_checker
   import rbc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic reset_pin_n,
   input wire logic watchdog_timer_reset,
   input wire logic power_on_reset,
   input wire logic [3:0] brownout_detector_below,
   input wire logic flash_init_start,
   input wire logic chip_reset,
   input wire logic [31:0] fetch_addr,
   input wire logic boot_block_mapped,
   input wire logic brownout_irq,
   input wire clock_ctl_t clock_ctl,
   input wire access_ctl_t access_ctl,
   input wire protect_level_t protect_level,
   input wire logic swd_debug_req,
   input wire logic core_debug_req
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_dbg;
      core_debug_req == (swd_debug_req && access_ctl.swd_enable);
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug gate wrong");
   property p_swd_rst; chip_reset |-> !access_ctl.swd_enable; endproperty
   a_swd_rst: assert property (p_swd_rst) else $error("swd in rst");
   property p_lvl; protect_level != PROT_NONE |-> !access_ctl.swd_enable;
   endproperty
   a_lvl: assert property (p_lvl) else $error("swd when protected");
   property p_calls; access_ctl.app_flash_calls_en; endproperty
   a_calls: assert property (p_calls) else $error("app calls off");
   property p_boot;
      $fell(chip_reset) |-> fetch_addr == 32'h0 && boot_block_mapped;
   endproperty
   a_boot: assert property (p_boot) else $error("bad boot fetch");
   property p_rc_clk;
      $fell(chip_reset) |-> clock_ctl.main_clk_sel == CLK_INTERNAL_RC &&
         clock_ctl.pll_power_down && clock_ctl.pll_bypass;
   endproperty
   a_rc_clk: assert property (p_rc_clk) else $error("clock not rc");
   property p_flash; flash_init_start |-> chip_reset ##1 !flash_init_start;
   endproperty
   a_flash: assert property (p_flash) else $error("flash init bad");
   property p_pin; $fell(reset_pin_n) |-> ##[1:6] chip_reset; endproperty
   a_pin: assert property (p_pin) else $error("pin reset missed");
   property p_wdog; watchdog_timer_reset |-> ##[1:6] chip_reset; endproperty
   a_wdog: assert property (p_wdog) else $error("wdog reset missed");
   property p_por; $rose(power_on_reset) |-> ##[1:6] chip_reset; endproperty
   a_por: assert property (p_por) else $error("por reset missed");
   property p_scan; (!reset_pin_n) [*4] |-> access_ctl.scan_select;
   endproperty
   a_scan: assert property (p_scan) else $error("scan off");
   property p_bo; (brownout_detector_below == 4'h0) [*4] |-> !brownout_irq;
   endproperty
   a_bo: assert property (p_bo) else $error("spurious irq");
   c_rel: cover property ($fell(chip_reset));
   c_dbg: cover property (core_debug_req);
   c_irq: cover property (brownout_irq);
endmodule

// ---- bench/test_reset_brownout_code_protect_ctrl.sv ----
`include "rbc_consts.svh"
`define CHK(nm, exp, got) \
   begin \
      compares++; \
      if ((got) !== (exp)) begin \
         err_total++; \
         $display("mismatch %s exp %h got %h", nm, exp, got); \
      end \
   end

module test_reset_brownout_code_protect_ctrl
   import rbc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] A_CTRL = {24'h0, `OFS_BROWNOUT_CTRL};
   localparam logic [31:0] A_STAT = {24'h0, `OFS_BROWNOUT_STAT};
   localparam logic [31:0] A_CAUSE = {24'h0, `OFS_RESET_CAUSE};
   localparam logic [31:0] A_CLK = {24'h0, `OFS_CLOCK_CTRL};
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, fetch_addr;
   logic [31:0] word_cfg = 32'h0, code_read_protection_word;
   logic pready, pslverr, reset_pin_n, watchdog_timer_reset = 1'b0;
   logic power_on_reset = 1'b0, supply_usable = 1'b1, pin_low = 1'b0;
   logic [3:0] brownout_detector_below = 4'h0;
   logic flash_init_start, flash_init_done, chip_reset, boot_block_mapped;
   logic brownout_irq, swd_debug_req, core_debug_req, slow = 1'b0, err_seen;
   clock_ctl_t clock_ctl;
   access_ctl_t access_ctl;
   protect_level_t protect_level;
   int err_total = 0, compares = 0, cycles = 0;

   reset_brownout_code_protect_ctrl dut_u (
      .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .reset_pin_n, .watchdog_timer_reset,
      .power_on_reset, .supply_usable, .brownout_detector_below,
      .flash_init_start, .flash_init_done, .code_read_protection_word,
      .chip_reset, .fetch_addr, .boot_block_mapped, .brownout_irq,
      .clock_ctl, .access_ctl, .protect_level, .swd_debug_req,
      .core_debug_req
   );
   host_model host_u (
      .clk, .pin_low_req(pin_low), .slow, .word_cfg, .flash_init_start,
      .reset_pin_n, .swd_debug_req, .flash_init_done,
      .code_read_protection_word
   );

   initial begin
      forever #25 clk = ~clk;
   end

   task automatic test_done();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         test_done();
      end
   end

   task automatic apb_go(input logic [31:0] a, input logic w,
      input logic [31:0] wd, output logic [31:0] rd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] x;
      apb_go(a, 1'b1, d, x);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] d;
      apb_go(a, 1'b0, 32'h0, d);
      `CHK("prdata", e, d)
   endtask

   task automatic wait_rst(input logic v);
      int n;
      n = 0;
      while (chip_reset !== v && n < 300) begin
         @(posedge clk);
         n++;
      end
      `CHK("chip_reset", v, chip_reset)
   endtask

   task automatic fire(input int i, input int hold);
      if (i == 3)
         wr(A_CTRL, 32'h14);
      case (i)
         0: pin_low <= 1'b1;
         1: watchdog_timer_reset <= 1'b1;
         2: power_on_reset <= 1'b1;
         default: brownout_detector_below <= 4'h2;
      endcase
      repeat (hold) @(posedge clk);
      if (hold > 1)
         `CHK("scan", 1'b1, access_ctl.scan_select)
      pin_low <= 1'b0;
      watchdog_timer_reset <= 1'b0;
      wait_rst(1'b1);
      `CHK("swd_off", 1'b0, access_ctl.swd_enable)
      power_on_reset <= 1'b0;
      brownout_detector_below <= 4'h0;
      wait_rst(1'b0);
      rd_chk(A_CAUSE, 32'h1 << i);
      wr(A_CAUSE, 32'hf);
      rd_chk(A_CAUSE, 32'h0);
   endtask

   initial begin
      logic [31:0] tbl [5];
      logic [31:0] d;
      logic [1:0] lvl;
      tbl = '{32'h0, 32'h1111, 32'h2222, 32'h3333, 32'h4444};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK("chip_reset", 1'b1, chip_reset)
      wait_rst(1'b0);
      `CHK("fetch_addr", 32'h0, fetch_addr)
      `CHK("boot_map", 1'b1, boot_block_mapped)
      rd_chk(A_CTRL, 32'h0);
      rd_chk(A_CLK, 32'h4);
      `CHK("rc_en", 1'b1, clock_ctl.internal_rc_enable)
      apb_go(32'h20, 1'b0, 32'h0, d);
      `CHK("unmapped", 33'h1_0000_0000, {err_seen, d})
      // Interrupt threshold two only
      wr(A_CTRL, 32'h2);
      brownout_detector_below <= 4'h4;
      repeat (4) @(posedge clk);
      `CHK("irq", 1'b1, brownout_irq)
      rd_chk(A_STAT, 32'h9);
      brownout_detector_below <= 4'h8;
      repeat (4) @(posedge clk);
      rd_chk(A_STAT, 32'h10);
      brownout_detector_below <= 4'h0;
      for (int j = 0; j < 5; j++) begin
         word_cfg <= tbl[j];
         slow <= j[0];
         wr(A_CLK, 32'h2);
         `CHK("clk_sel", CLK_PLL, clock_ctl.main_clk_sel)
         fire(j % 4, (j == 4) ? 8 : 1);
         lvl = (j == 4) ? 2'h0 : j[1:0];
         `CHK("level", lvl, protect_level)
         `CHK("swd", lvl == 2'h0, access_ctl.swd_enable)
         `CHK("app_calls", 1'b1, access_ctl.app_flash_calls_en)
         `CHK("sector0", lvl == 2'h1, access_ctl.sector0_locked)
         `CHK("erase", lvl == 2'h2, access_ctl.erase_before_update)
         `CHK("boot", lvl != 2'h3, access_ctl.serial_boot_allowed)
         `CHK("pin_smp", j < 3, access_ctl.boot_pin_sample_en)
         rd_chk(A_CLK, 32'h4);
      end
      // Supply loss parks the sequencer and stops the oscillator
      supply_usable <= 1'b0;
      wait_rst(1'b1);
      `CHK("rc_off", 1'b0, clock_ctl.internal_rc_enable)
      supply_usable <= 1'b1;
      wait_rst(1'b0);
      `CHK("rc_on", 1'b1, clock_ctl.internal_rc_enable)
      test_done();
   end
endmodule

bind reset_brownout_code_protect_ctrl rbc_checker chk_u (
   .clk, .rst, .reset_pin_n, .watchdog_timer_reset, .power_on_reset,
   .brownout_detector_below, .flash_init_start, .chip_reset, .fetch_addr,
   .boot_block_mapped, .brownout_irq, .clock_ctl, .access_ctl,
   .protect_level, .swd_debug_req, .core_debug_req
);

// ---- hw/level_sync.sv ----
module level_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   generate
      if (WIDTH < 1) begin : g_chk
         $error("level_sync needs WIDTH of at least one");
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= INIT;
         sync_out <= INIT;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// ---- hw/reset_brownout_code_protect_ctrl.sv ----
// Implementation choices: the register offsets and register access over APB.
`include "rbc_consts.svh"

module reset_brownout_code_protect_ctrl
   import rbc_pkg::*;
#(
   parameter logic [31:0] PATTERN_LEVEL_ONE = 32'h0000_1111,
   parameter logic [31:0] PATTERN_LEVEL_TWO = 32'h0000_2222,
   parameter logic [31:0] PATTERN_LEVEL_THREE = 32'h0000_3333,
   parameter logic [31:0] PATTERN_NO_BOOT_PIN = 32'h0000_4444,
   parameter int OSC_START_CYCLES = `OSC_START_CYC,
   parameter int PIN_MIN_CYCLES = `PIN_MIN_LOW_CYC
) (
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reset causes and supply
   input wire logic reset_pin_n,
   input wire logic watchdog_timer_reset,
   input wire logic power_on_reset,
   input wire logic supply_usable,
   input wire logic [3:0] brownout_detector_below,
   // Flash controller
   output logic flash_init_start,
   input wire logic flash_init_done,
   input wire logic [31:0] code_read_protection_word,
   // Core and system
   output logic chip_reset,
   output logic [31:0] fetch_addr,
   output logic boot_block_mapped,
   output logic brownout_irq,
   output clock_ctl_t clock_ctl,
   output access_ctl_t access_ctl,
   output protect_level_t protect_level,
   input wire logic swd_debug_req,
   output logic core_debug_req
);

   typedef enum logic [2:0] {
      S_OFF,
      S_OSC_START,
      S_FLASH_INIT,
      S_HOLD,
      S_RUN
   } seq_state_t;

   generate
      if (OSC_START_CYCLES < 1 || OSC_START_CYCLES > 255) begin : g_osc
         $error("OSC_START_CYCLES must be 1 to 255");
      end
      if (PIN_MIN_CYCLES < 1 || PIN_MIN_CYCLES > 15) begin : g_pin
         $error("PIN_MIN_CYCLES must be 1 to 15");
      end
   endgenerate

   // Synchronised asynchronous inputs
   logic pin_n_s;
   logic por_s;
   logic supply_s;
   logic [3:0] below_s;

   level_sync #(
      .WIDTH(3),
      .INIT(3'h5)
   ) u_sync_ctl (
      .clk(clk),
      .rst(rst),
      .async_in({reset_pin_n, power_on_reset, supply_usable}),
      .sync_out({pin_n_s, por_s, supply_s})
   );

   level_sync #(
      .WIDTH(4),
      .INIT(4'h0)
   ) u_sync_brownout (
      .clk(clk),
      .rst(rst),
      .async_in(brownout_detector_below),
      .sync_out(below_s)
   );

   seq_state_t state_q;
   seq_state_t state_d;
   logic [3:0] pin_cnt_q;
   logic [7:0] osc_cnt_q;
   logic watchdog_pend_q;
   logic chip_reset_q;
   logic [31:0] ctrl_q;
   logic [31:0] clkc_q;
   logic [3:0] cause_q;
   protect_level_t level_q;
   logic no_boot_pin_q;
   logic [31:0] prdata_q;
   logic [31:0] fetch_q;
   logic boot_map_q;
   logic flash_start_q;

   // Pin low long enough counts as a reset cause
   logic pin_cause;
   assign pin_cause = (pin_cnt_q >= 4'(PIN_MIN_CYCLES));

   always_ff @(posedge clk) begin
      if (rst || pin_n_s) begin
         pin_cnt_q <= 4'h0;
      end else if (!pin_cause) begin
         pin_cnt_q <= pin_cnt_q + 4'h1;
      end
   end

   // Brownout threshold selection
   logic [1:0] irq_lvl;
   logic [1:0] rst_lvl;
   logic brown_rst_en;
   logic brown_rst;
   assign irq_lvl = ctrl_q[`BOC_IRQ_LVL_LSB +: 2];
   assign rst_lvl = ctrl_q[`BOC_RST_LVL_LSB +: 2];
   assign brown_rst_en = ctrl_q[`BOC_RST_EN_BIT];
   assign brownout_irq = below_s[irq_lvl];
   assign brown_rst = brown_rst_en && below_s[rst_lvl];

   logic any_cause;
   assign any_cause = pin_cause || watchdog_pend_q || por_s
      || brown_rst;

   // Watchdog pulse held until the sequencer reaches the hold state
   always_ff @(posedge clk) begin
      if (rst) begin
         watchdog_pend_q <= 1'b0;
      end else if (watchdog_timer_reset) begin
         watchdog_pend_q <= 1'b1;
      end else if (state_q == S_HOLD) begin
         watchdog_pend_q <= 1'b0;
      end
   end

   // Reset sequencer
   logic osc_done;
   assign osc_done = (osc_cnt_q == 8'(OSC_START_CYCLES - 1));

   always_comb begin
      state_d = state_q;
      case (state_q)
         S_OFF: begin
            if (supply_s) begin
               state_d = S_OSC_START;
            end
         end
         S_OSC_START: begin
            if (osc_done) begin
               state_d = S_FLASH_INIT;
            end
         end
         S_FLASH_INIT: begin
            if (flash_init_done) begin
               state_d = S_HOLD;
            end
         end
         S_HOLD: begin
            if (!any_cause) begin
               state_d = S_RUN;
            end
         end
         S_RUN: begin
            if (any_cause) begin
               state_d = S_OSC_START;
            end
         end
         default: state_d = S_OFF;
      endcase
      if (!supply_s) begin
         state_d = S_OFF;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= S_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || state_q != S_OSC_START) begin
         osc_cnt_q <= 8'h00;
      end else if (!osc_done) begin
         osc_cnt_q <= osc_cnt_q + 8'h01;
      end
   end

   // One-cycle flash init start on entering flash init
   always_ff @(posedge clk) begin
      if (rst) begin
         flash_start_q <= 1'b0;
      end else begin
         flash_start_q <= (state_q == S_OSC_START) && osc_done;
      end
   end
   assign flash_init_start = flash_start_q;

   // Internal reset, released on a clock edge only
   always_ff @(posedge clk) begin
      if (rst) begin
         chip_reset_q <= 1'b1;
      end else begin
         chip_reset_q <= (state_d != S_RUN);
      end
   end
   assign chip_reset = chip_reset_q;

   // Registers reset by rst and by the internal chip reset
   logic soft_rst;
   assign soft_rst = rst || chip_reset_q;

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         fetch_q <= `BOOT_FETCH_ADDR;
         boot_map_q <= 1'b1;
      end else begin
         fetch_q <= fetch_q;
         boot_map_q <= boot_map_q;
      end
   end
   assign fetch_addr = fetch_q;
   assign boot_block_mapped = boot_map_q;

   // Protection level captured from flash at init completion
   protect_level_t level_dec;
   logic no_boot_pin_dec;
   assign level_dec =
      (code_read_protection_word == PATTERN_LEVEL_ONE) ? PROT_ONE :
      (code_read_protection_word == PATTERN_LEVEL_TWO) ? PROT_TWO :
      (code_read_protection_word == PATTERN_LEVEL_THREE) ? PROT_THREE :
      PROT_NONE;
   assign no_boot_pin_dec =
      (code_read_protection_word == PATTERN_NO_BOOT_PIN);

   always_ff @(posedge clk) begin
      if (rst) begin
         level_q <= PROT_NONE;
         no_boot_pin_q <= 1'b0;
      end else if (state_q == S_FLASH_INIT && flash_init_done) begin
         level_q <= level_dec;
         no_boot_pin_q <= no_boot_pin_dec;
      end
   end
   assign protect_level = level_q;

   // Access control
   logic scan_sel;
   logic swd_on;
   assign scan_sel = !pin_n_s;
   assign swd_on = !chip_reset_q && pin_n_s
      && (level_q == PROT_NONE);
   assign access_ctl.swd_enable = swd_on;
   assign access_ctl.scan_select = scan_sel;
   assign access_ctl.serial_boot_allowed =
      (level_q != PROT_THREE);
   assign access_ctl.sector0_locked = (level_q == PROT_ONE);
   assign access_ctl.erase_before_update =
      (level_q == PROT_TWO);
   assign access_ctl.boot_pin_sample_en =
      !no_boot_pin_q && (level_q != PROT_THREE);
   assign access_ctl.app_flash_calls_en = 1'b1;
   assign core_debug_req = swd_debug_req && swd_on;

   // Sticky reset cause record, kept across chip reset
   logic [3:0] cause_set;
   logic cause_clr;
   logic [3:0] cause_d;
   assign cause_set[`RC_PIN_BIT] = pin_cause;
   assign cause_set[`RC_WATCHDOG_BIT] = watchdog_pend_q;
   assign cause_set[`RC_POR_BIT] = por_s;
   assign cause_set[`RC_BROWNOUT_BIT] = brown_rst;

   // APB decode
   logic setup;
   logic access;
   logic wr;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_cause;
   logic hit_prot;
   logic hit_clk;
   logic hit_any;
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign hit_ctrl = (paddr == 32'(`OFS_BROWNOUT_CTRL));
   assign hit_stat = (paddr == 32'(`OFS_BROWNOUT_STAT));
   assign hit_cause = (paddr == 32'(`OFS_RESET_CAUSE));
   assign hit_prot = (paddr == 32'(`OFS_PROTECT_STAT));
   assign hit_clk = (paddr == 32'(`OFS_CLOCK_CTRL));
   assign hit_any = hit_ctrl || hit_stat || hit_cause || hit_prot
      || hit_clk;
   assign pready = 1'b1;
   assign pslverr = access && !hit_any;
   assign cause_clr = wr && hit_cause;
   assign cause_d = (cause_q & ~(cause_clr ? pwdata[3:0] : 4'h0))
      | cause_set;

   always_ff @(posedge clk) begin
      if (rst) begin
         cause_q <= 4'h0;
      end else begin
         cause_q <= cause_d;
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         ctrl_q <= `BOC_RESET;
      end else if (wr && hit_ctrl) begin
         ctrl_q <= {27'h0, pwdata[4:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         clkc_q <= `CKC_RESET;
      end else if (wr && hit_clk) begin
         clkc_q <= {29'h0, pwdata[2:0]};
      end
   end

   // Clock source control: internal oscillator after any reset
   assign clock_ctl.main_clk_sel = clk_src_t'(clkc_q[`CKC_SEL_LSB +: 2]);
   assign clock_ctl.pll_power_down = clkc_q[`CKC_PLL_PD_BIT];
   assign clock_ctl.pll_bypass =
      (clock_ctl.main_clk_sel != CLK_PLL);
   assign clock_ctl.internal_rc_enable = (state_q != S_OFF)
      && (chip_reset_q || clock_ctl.main_clk_sel == CLK_INTERNAL_RC
      || clock_ctl.main_clk_sel == CLK_PLL);

   // Read data captured in the setup cycle
   logic [31:0] rd_mux;
   assign rd_mux =
      hit_ctrl ? ctrl_q :
      hit_stat ? {27'h0, below_s, brownout_irq} :
      hit_cause ? {28'h0, cause_q} :
      hit_prot ? {29'h0, no_boot_pin_q, level_q} :
      hit_clk ? clkc_q :
      32'h0000_0000;

   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup) begin
         prdata_q <= rd_mux;
      end
   end
   assign prdata = prdata_q;

endmodule

// ---- pkg/rbc_consts.svh ----
`ifndef RBC_CONSTS_SVH
`define RBC_CONSTS_SVH

// Register byte offsets
`define OFS_BROWNOUT_CTRL 8'h00
`define OFS_BROWNOUT_STAT 8'h04
`define OFS_RESET_CAUSE 8'h08
`define OFS_PROTECT_STAT 8'h0c
`define OFS_CLOCK_CTRL 8'h10

// Brownout control fields
`define BOC_IRQ_LVL_LSB 0
`define BOC_RST_LVL_LSB 2
`define BOC_RST_EN_BIT 4
`define BOC_RESET 32'h0000_0000

// Clock control fields
`define CKC_SEL_LSB 0
`define CKC_PLL_PD_BIT 2
`define CKC_RESET 32'h0000_0004

// Reset cause bit positions
`define RC_PIN_BIT 0
`define RC_WATCHDOG_BIT 1
`define RC_POR_BIT 2
`define RC_BROWNOUT_BIT 3

// Boot fetch address after release
`define BOOT_FETCH_ADDR 32'h0000_0000

// Timing
`define CLK_PERIOD_NS 50
`define PIN_MIN_LOW_NS 50
`define PIN_MIN_LOW_CYC \
   ((`PIN_MIN_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_START_NS 500
`define OSC_START_CYC \
   ((`OSC_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- pkg/rbc_pkg.sv ----
package rbc_pkg;

   typedef enum logic [1:0] {
      PROT_NONE,
      PROT_ONE,
      PROT_TWO,
      PROT_THREE
   } protect_level_t;

   typedef enum logic [1:0] {
      CLK_INTERNAL_RC,
      CLK_SYSOSC,
      CLK_PLL,
      CLK_WDOSC
   } clk_src_t;

   // Access permissions handed to debug and boot logic
   typedef struct packed {
      logic swd_enable;
      logic scan_select;
      logic serial_boot_allowed;
      logic sector0_locked;
      logic erase_before_update;
      logic boot_pin_sample_en;
      logic app_flash_calls_en;
   } access_ctl_t;

   typedef struct packed {
      clk_src_t main_clk_sel;
      logic pll_power_down;
      logic pll_bypass;
      logic internal_rc_enable;
   } clock_ctl_t;

endpackage
